// ### core/sts_supervisor.sv
`timescale 1ns/1ps
// Operation
// - Over warning temperature: save warning, flag set.
// - Shutdown temperature: Reset, sticky flag, supplies off.
// - Cooled down: Start-Up, then Stand-By, oscillator.
// - Warning flag follows temperature by itself.
// - Shutdown flag clears on read when cool.
// - Sleep request bit puts device to Sleep.
// - Leave Sleep by wake pulse; report it.
// - Sleep request ignored while wake pin low.
// - Watchdog idle until enable bit written one.
// - Early or late refresh pulls host reset.
// - Period code picks timeout and early window.
// - Filter at start level: fixed converter, Start-Up.
// - Core supply good, trim read: Stand-By.
// - On Stand-By entry sample bus good.
// - Start oscillator 2 ms into Stand-By.
// - Filter high: adjustable converter, 20 V on.
// - Normal only when every good condition holds.
// - Filtered bus loss: flag clear, Stand-By, warning.
// - Filter low: adjustable converter, 20 V off.
// - Filter off level, core loss: converter off, Reset.
// - Stand-By from Normal: 4 MHz on oscillator fault.
module sts_supervisor
    import sts_pkg::*;
#(
    parameter int unsigned OSC_DELAY_CYCLES = OSC_DELAY_CYC,
    parameter int unsigned BUS_FILTER_CYCLES = BUS_FILTER_CYC,
    parameter int unsigned CYCLES_PER_MS_P = CYCLES_PER_MS
)
(
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Avalon-MM slave.
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Comparator and status inputs, high when the condition holds.
    input wire logic temp_warn_cmp,
    input wire logic temp_shutdown_cmp,
    input wire logic filt_start_cmp,
    input wire logic filt_above_high_cmp,
    input wire logic filt_below_low_cmp,
    input wire logic filt_above_off_cmp,
    input wire logic core_supply_ok_cmp,
    input wire logic bus_above_high_cmp,
    input wire logic bus_below_low_cmp,
    input wire logic adjustable_supply_ok,
    input wire logic twenty_volt_ok,
    input wire logic osc_running,
    input wire logic trim_read_done,
    input wire logic fan_in_wake_pin,
    // Open-drain host pins.
    input wire logic save_warning_n_i,
    output logic save_warning_n_o,
    output logic save_warning_n_oe,
    input wire logic host_reset_request_n_i,
    output logic host_reset_request_n_o,
    output logic host_reset_request_n_oe,
    // Power and clock controls.
    output logic fixed_converter_en,
    output logic adjustable_converter_en,
    output logic twenty_volt_en,
    output logic osc_en,
    output logic [1:0] host_clock_out_sel
);
    sts_wd_if wd_link(); // Watchdog control link.

    logic [N_IN-1:0] raw_in; // Unsynchronised inputs.
    logic [N_IN-1:0] meta_in; // First synchroniser stage.
    logic [N_IN-1:0] sync_in; // Second synchroniser stage.
    logic wake_prev; // Wake pin level one cycle ago.
    logic wake_fall; // Falling edge on the wake pin.

    sts_state_e state; // Current supervisor state.
    sts_state_e next_state; // State for the next cycle.

    logic normal_ok; // All conditions for Normal hold.
    logic thermal_warning_flag; // Live over-temperature warning.
    logic thermal_shutdown_flag; // Sticky shutdown record.
    logic sleep_exit_flag; // Sleep was left by a wake pulse.
    logic bus_voltage_good; // Bus supervisor flag.
    logic filter_voltage_good; // Filter supervisor flag.
    logic xtal_fault; // Normal was left for an oscillator fault.
    logic sleep_request_bit; // Pending sleep request.
    logic [3:0] watchdog_period_sel; // Watchdog period code.
    logic [31:0] bus_low_cnt; // Cycles the bus has stayed low.
    logic bus_fail; // Bus low longer than the filter time.
    logic [31:0] osc_cnt; // Cycles since Stand-By entry.
    logic [7:0] wd_pulse_cnt; // Remaining host reset pulse cycles.
    logic [31:0] read_mux; // Read value for the addressed register.
    logic access; // Bus transfer completes this edge.
    logic wr_ctrl; // Completing write to the control register.
    logic wr_wdog; // Completing write to the watchdog register.
    logic rd_status; // Completing read of the status register.

    assign raw_in = {fan_in_wake_pin, trim_read_done, osc_running, twenty_volt_ok,
                     adjustable_supply_ok, bus_below_low_cmp, bus_above_high_cmp,
                     core_supply_ok_cmp, filt_above_off_cmp, filt_below_low_cmp,
                     filt_above_high_cmp, filt_start_cmp, temp_shutdown_cmp,
                     temp_warn_cmp};

    // Two-stage synchroniser per input; only the second stage is used.
    for (genvar i = 0; i < N_IN; i++)
    begin : g_sync
        always_ff @(posedge clk)
        begin
            meta_in[i] <= raw_in[i];
            sync_in[i] <= meta_in[i];
        end
    end

    // Wake edge detector; the pin idles high via its pull-up.
    always_ff @(posedge clk)
    begin
        if (rst)
            wake_prev <= 1'b1;
        else
            wake_prev <= sync_in[IN_WAKE];
    end
    assign wake_fall = wake_prev && !sync_in[IN_WAKE];

    // Bus transfer decode; the action happens at the waitrequest-low edge.
    assign access = (avs_read || avs_write) && !avs_waitrequest;
    assign wr_ctrl = access && avs_write && avs_address == ADDR_CTRL && avs_byteenable[0];
    assign wr_wdog = access && avs_write && avs_address == ADDR_WDOG && avs_byteenable[0];
    assign rd_status = access && avs_read && avs_address == ADDR_STATUS;

    // Watchdog connection.
    assign wd_link.kick = wr_wdog && avs_writedata[WDOG_EN_BIT];
    assign wd_link.stop = wr_wdog && !avs_writedata[WDOG_EN_BIT];
    assign wd_link.period_sel = watchdog_period_sel;

    sts_watchdog #(
        .CYCLES_PER_MS_P(CYCLES_PER_MS_P)
    ) u_watchdog (
        .clk(clk),
        .rst(rst),
        .wd(wd_link.wdog)
    );

    assign normal_ok = sync_in[IN_OSC_RUN] && !thermal_warning_flag
                       && !sync_in[IN_TSD] && bus_voltage_good && filter_voltage_good
                       && sync_in[IN_ADJUSTABLE_SUPPLY_GOOD_OK] && sync_in[IN_V20_OK];

    // State transitions; shutdown temperature has priority everywhere but Sleep.
    always_comb
    begin
        next_state = state;
        unique case (state)
            ST_RESET:
                // Stay in Reset while hot.
                if (!sync_in[IN_TSD] && sync_in[IN_FILT_START])
                    next_state = ST_STARTUP;
            ST_STARTUP:
                if (sync_in[IN_TSD] || !sync_in[IN_FILT_OFF])
                    next_state = ST_RESET;
                else if (sync_in[IN_CORE_OK] && sync_in[IN_TRIM_DONE])
                    next_state = ST_STANDBY;
            ST_STANDBY:
                if (sync_in[IN_TSD] || !sync_in[IN_CORE_OK])
                    next_state = ST_RESET;
                else if (sleep_request_bit)
                    next_state = ST_SLEEP;
                else if (normal_ok)
                    next_state = ST_NORMAL;
            ST_NORMAL:
                if (sync_in[IN_TSD] || !sync_in[IN_CORE_OK])
                    next_state = ST_RESET;
                else if (sleep_request_bit)
                    next_state = ST_SLEEP;
                else if (bus_fail || !normal_ok)
                    next_state = ST_STANDBY;
            ST_SLEEP:
                // Only a wake pulse or power-on reset ends Sleep.
                if (wake_fall)
                    next_state = ST_RESET;
            default:
                next_state = ST_RESET;
        endcase
    end

    // State register.
    always_ff @(posedge clk)
    begin
        if (rst)
            state <= ST_RESET;
        else
            state <= next_state;
    end

    // Thermal flags; a hot reading wins over a clearing read.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            thermal_warning_flag <= 1'b0;
            thermal_shutdown_flag <= 1'b0;
        end
        else
        begin
            thermal_warning_flag <= sync_in[IN_TW];
            if (sync_in[IN_TSD])
                thermal_shutdown_flag <= 1'b1;
            else if (rd_status)
                thermal_shutdown_flag <= 1'b0;
        end
    end

    // Sleep request and sleep-exit report.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            sleep_request_bit <= 1'b0;
            sleep_exit_flag <= 1'b0;
        end
        else
        begin
            // A held-low wake pin refuses and cancels the request.
            if (state == ST_SLEEP || !sync_in[IN_WAKE])
                sleep_request_bit <= 1'b0;
            else if (wr_ctrl)
                sleep_request_bit <= avs_writedata[CTRL_SLEEP_BIT];
            if (state == ST_SLEEP && wake_fall)
                sleep_exit_flag <= 1'b1;
            else if (rd_status)
                sleep_exit_flag <= 1'b0;
        end
    end

    // Bus low filter; the flag only drops after the full filter time.
    always_ff @(posedge clk)
    begin
        if (rst || !sync_in[IN_BUS_LOW] || state == ST_RESET || state == ST_SLEEP)
            bus_low_cnt <= '0;
        else if (!bus_fail)
            bus_low_cnt <= bus_low_cnt + 32'h1;
    end
    assign bus_fail = (bus_low_cnt >= BUS_FILTER_CYCLES);

    // Bus and filter supervisor flags.
    always_ff @(posedge clk)
    begin
        if (rst || state == ST_RESET || state == ST_STARTUP || state == ST_SLEEP)
        begin
            bus_voltage_good <= 1'b0;
            filter_voltage_good <= 1'b0;
            // Sample the bus right at Stand-By entry.
            if (!rst && state == ST_STARTUP && next_state == ST_STANDBY)
                bus_voltage_good <= sync_in[IN_BUS_HIGH];
        end
        else
        begin
            if (bus_fail)
                bus_voltage_good <= 1'b0;
            else if (sync_in[IN_BUS_HIGH])
                bus_voltage_good <= 1'b1;
            if (sync_in[IN_FILT_HIGH])
                filter_voltage_good <= 1'b1;
            else if (sync_in[IN_FILT_LOW])
                filter_voltage_good <= 1'b0;
        end
    end

    // Oscillator start delay, counted from Stand-By entry.
    always_ff @(posedge clk)
    begin
        if (rst || state != ST_STANDBY)
            osc_cnt <= '0;
        else if (osc_cnt < OSC_DELAY_CYCLES)
            osc_cnt <= osc_cnt + 32'h1;
    end

    // Oscillator enable; once running it survives the drop to Stand-By.
    always_ff @(posedge clk)
    begin
        if (rst || state == ST_RESET || state == ST_STARTUP || state == ST_SLEEP)
            osc_en <= 1'b0;
        else if (state == ST_NORMAL || osc_cnt >= OSC_DELAY_CYCLES)
            osc_en <= 1'b1;
    end

    // Oscillator fault memory for the host clock choice.
    always_ff @(posedge clk)
    begin
        if (rst || state == ST_RESET || next_state == ST_NORMAL)
            xtal_fault <= 1'b0;
        else if (state == ST_NORMAL && next_state == ST_STANDBY && !sync_in[IN_OSC_RUN])
            xtal_fault <= 1'b1;
    end

    // Host clock: 4 MHz after start-up, 8 MHz kept unless the crystal failed.
    always_ff @(posedge clk)
    begin
        if (rst)
            host_clock_out_sel <= CLKSEL_OFF;
        else
            unique case (state)
                ST_NORMAL:
                    host_clock_out_sel <= CLKSEL_8M;
                ST_STANDBY:
                    if (xtal_fault || host_clock_out_sel != CLKSEL_8M)
                        host_clock_out_sel <= CLKSEL_4M;
                default:
                    host_clock_out_sel <= CLKSEL_OFF;
            endcase
    end

    // Converter enables; all supplies stop in Reset and Sleep.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            fixed_converter_en <= 1'b0;
            adjustable_converter_en <= 1'b0;
            twenty_volt_en <= 1'b0;
        end
        else
        begin
            fixed_converter_en <= (state == ST_STARTUP || state == ST_STANDBY
                                   || state == ST_NORMAL)
                                  && sync_in[IN_FILT_OFF];
            adjustable_converter_en <= filter_voltage_good
                                       && (state == ST_STANDBY || state == ST_NORMAL);
            twenty_volt_en <= filter_voltage_good
                              && (state == ST_STANDBY || state == ST_NORMAL);
        end
    end

    // Host reset pulse length after a watchdog fault.
    always_ff @(posedge clk)
    begin
        if (rst)
            wd_pulse_cnt <= '0;
        else if (wd_link.fire)
            wd_pulse_cnt <= WD_PULSE_CYC;
        else if (wd_pulse_cnt != 8'h0)
            wd_pulse_cnt <= wd_pulse_cnt - 8'h1;
    end

    // Open-drain drivers; the pins only ever pull low.
    always_ff @(posedge clk)
    begin
        save_warning_n_o <= 1'b0;
        host_reset_request_n_o <= 1'b0;
        if (rst)
        begin
            save_warning_n_oe <= 1'b1;
            host_reset_request_n_oe <= 1'b1;
        end
        else
        begin
            save_warning_n_oe <= !(next_state == ST_NORMAL && !sync_in[IN_TW]);
            host_reset_request_n_oe <= next_state == ST_RESET || next_state == ST_STARTUP
                                       || next_state == ST_SLEEP
                                       || wd_link.fire || wd_pulse_cnt > 8'h1;
        end
    end

    // Watchdog period code, written with the enable bit.
    always_ff @(posedge clk)
    begin
        if (rst)
            watchdog_period_sel <= 4'h0;
        else if (wr_wdog)
            watchdog_period_sel <= avs_writedata[WDOG_SEL_LSB +: 4];
    end

    // Read data; unmapped offsets read zero.
    always_comb
    begin
        read_mux = 32'h0;
        unique case (avs_address)
            ADDR_CTRL:
                read_mux[CTRL_SLEEP_BIT] = sleep_request_bit;
            ADDR_WDOG:
            begin
                read_mux[WDOG_EN_BIT] = wd_link.armed;
                read_mux[WDOG_SEL_LSB +: 4] = watchdog_period_sel;
            end
            ADDR_STATUS:
                read_mux[13:0] = {host_reset_request_n_i, save_warning_n_i, xtal_fault,
                                  state, sync_in[IN_OSC_RUN], sync_in[IN_V20_OK],
                                  sync_in[IN_ADJUSTABLE_SUPPLY_GOOD_OK], filter_voltage_good,
                                  bus_voltage_good, sleep_exit_flag,
                                  thermal_shutdown_flag, thermal_warning_flag};
            default:
                read_mux = 32'h0;
        endcase
    end

    // Avalon handshake: one wait cycle, then the transfer completes.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0;
        end
        else if ((avs_read || avs_write) && avs_waitrequest)
        begin
            avs_waitrequest <= 1'b0;
            avs_readdata <= avs_read ? read_mux : 32'h0;
        end
        else
            avs_waitrequest <= 1'b1;
    end
endmodule : sts_supervisor

// ### core/sts_pkg.sv
package sts_pkg;
    // Supervisor states, binary coded.
    typedef enum logic [2:0] {
        ST_RESET = 3'b000,
        ST_STARTUP = 3'b001,
        ST_STANDBY = 3'b010,
        ST_NORMAL = 3'b011,
        ST_SLEEP = 3'b100
    } sts_state_e;

    // Register byte offsets.
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_WDOG = 4'h4;
    localparam logic [3:0] ADDR_STATUS = 4'h8;

    // Field positions.
    localparam int CTRL_SLEEP_BIT = 0;
    localparam int WDOG_EN_BIT = 0;
    localparam int WDOG_SEL_LSB = 4;

    // Host clock selection codes.
    localparam logic [1:0] CLKSEL_OFF = 2'h0;
    localparam logic [1:0] CLKSEL_4M = 2'h1;
    localparam logic [1:0] CLKSEL_8M = 2'h2;

    // Timing in microseconds and derived cycle counts.
    localparam int unsigned CLK_MHZ = 100;
    localparam int unsigned OSC_DELAY_US = 2000;
    localparam int unsigned BUS_FILTER_US = 2000;
    localparam int unsigned OSC_DELAY_CYC = OSC_DELAY_US * CLK_MHZ;
    localparam int unsigned BUS_FILTER_CYC = BUS_FILTER_US * CLK_MHZ;
    localparam int unsigned CYCLES_PER_MS = 1000 * CLK_MHZ;
    localparam logic [7:0] WD_PULSE_CYC = 8'h10;

    // Watchdog timeout and early window per period code, in ms.
    localparam logic [9:0] WD_TIMEOUT_MS [16] = '{
        10'd33, 10'd66, 10'd98, 10'd131, 10'd164, 10'd197, 10'd229, 10'd262,
        10'd295, 10'd328, 10'd360, 10'd393, 10'd426, 10'd459, 10'd492, 10'd524
    };
    localparam logic [9:0] WD_EARLY_MS [16] = '{
        10'd2, 10'd4, 10'd6, 10'd8, 10'd10, 10'd12, 10'd14, 10'd16,
        10'd18, 10'd20, 10'd23, 10'd25, 10'd27, 10'd29, 10'd30, 10'd31
    };

    // Index of each comparator input in the synchroniser vector.
    localparam int IN_TW = 0;
    localparam int IN_TSD = 1;
    localparam int IN_FILT_START = 2;
    localparam int IN_FILT_HIGH = 3;
    localparam int IN_FILT_LOW = 4;
    localparam int IN_FILT_OFF = 5;
    localparam int IN_CORE_OK = 6;
    localparam int IN_BUS_HIGH = 7;
    localparam int IN_BUS_LOW = 8;
    localparam int IN_ADJUSTABLE_SUPPLY_GOOD_OK = 9;
    localparam int IN_V20_OK = 10;
    localparam int IN_OSC_RUN = 11;
    localparam int IN_TRIM_DONE = 12;
    localparam int IN_WAKE = 13;
    localparam int N_IN = 14;
endpackage : sts_pkg

// ### core/sts_wd_if.sv
`timescale 1ns/1ps
// Link between the register file and the watchdog timer.
interface sts_wd_if;
    logic kick;
    logic stop;
    logic [3:0] period_sel;
    logic fire;
    logic armed;
    modport ctrl (output kick, output stop, output period_sel, input fire, input armed);
    modport wdog (input kick, input stop, input period_sel, output fire, output armed);
endinterface : sts_wd_if

// ### core/sts_watchdog.sv
`timescale 1ns/1ps
module sts_watchdog
    import sts_pkg::*;
#(
    parameter int unsigned CYCLES_PER_MS_P = CYCLES_PER_MS
)
(
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Register side.
    sts_wd_if.wdog wd
);
    logic [31:0] prescale; // Cycles within the current millisecond.
    logic [9:0] ms_count; // Milliseconds since the last refresh.
    logic ms_tick; // Last cycle of a millisecond.

    assign ms_tick = (prescale == CYCLES_PER_MS_P - 1);

    // Millisecond prescaler, restarted by every refresh.
    always_ff @(posedge clk)
    begin
        if (rst || wd.kick || !wd.armed || ms_tick)
            prescale <= '0;
        else
            prescale <= prescale + 32'h1;
    end

    // Elapsed milliseconds, saturating so it never wraps back into the window.
    always_ff @(posedge clk)
    begin
        if (rst || wd.kick || !wd.armed)
            ms_count <= '0;
        else if (ms_tick && ms_count != 10'h3ff)
            ms_count <= ms_count + 10'h1;
    end

    // Arming, refresh checks and the reset pulse request.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            wd.armed <= 1'b0;
            wd.fire <= 1'b0;
        end
        else
        begin
            wd.fire <= 1'b0;
            if (wd.stop)
                wd.armed <= 1'b0;
            else if (wd.kick)
            begin
                // A refresh inside the early window is as bad as none.
                if (wd.armed && ms_count < WD_EARLY_MS[wd.period_sel])
                begin
                    wd.fire <= 1'b1;
                    wd.armed <= 1'b0;
                end
                else
                    wd.armed <= 1'b1;
            end
            else if (wd.armed && ms_count >= WD_TIMEOUT_MS[wd.period_sel])
            begin
                wd.fire <= 1'b1;
                wd.armed <= 1'b0;
            end
        end
    end
endmodule : sts_watchdog

// ### testbench/sts_supervisor_checker.sv
`timescale 1ns/1ps
// Watches the supervisor pins; latencies allow for the two-flop input sync.
module sts_supervisor_checker
    import sts_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Watched inputs.
    input wire logic temp_warn_cmp,
    input wire logic temp_shutdown_cmp,
    input wire logic filt_below_low_cmp,
    // Watched outputs.
    input wire logic save_warning_n_oe,
    input wire logic host_reset_request_n_oe,
    input wire logic fixed_converter_en,
    input wire logic adjustable_converter_en,
    input wire logic twenty_volt_en,
    input wire logic osc_en,
    input wire logic [1:0] host_clock_out_sel
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    property p_warn; temp_warn_cmp [*3] |-> ##[0:4] save_warning_n_oe; endproperty
    a_warn: assert property (p_warn) else $error("save pin not pulled");
    property p_tsd; temp_shutdown_cmp [*3] |-> ##[0:4] (host_reset_request_n_oe && !fixed_converter_en); endproperty
    a_tsd: assert property (p_tsd) else $error("no shutdown");
    property p_norm; $fell(save_warning_n_oe) |-> ##[1:2] host_clock_out_sel == CLKSEL_8M; endproperty
    a_norm: assert property (p_norm) else $error("normal clock wrong");
    property p_rel; $fell(host_reset_request_n_oe) |-> fixed_converter_en; endproperty
    a_rel: assert property (p_rel) else $error("reset released early");
    property p_osc; $fell(host_reset_request_n_oe) && !osc_en |-> ##1 !osc_en [*8]; endproperty
    a_osc: assert property (p_osc) else $error("oscillator early");
    property p_wdp; $rose(host_reset_request_n_oe) |-> host_reset_request_n_oe [*8]; endproperty
    a_wdp: assert property (p_wdp) else $error("reset pulse short");
    property p_ord; adjustable_converter_en |-> fixed_converter_en; endproperty
    a_ord: assert property (p_ord) else $error("converter order");
    property p_flo; filt_below_low_cmp [*4] |-> ##[0:3] !(adjustable_converter_en || twenty_volt_en); endproperty
    a_flo: assert property (p_flo) else $error("filter low ignored");
    c_norm: cover property ($fell(save_warning_n_oe));
    c_osc: cover property ($rose(osc_en));
    c_wdog: cover property ($rose(host_reset_request_n_oe) && fixed_converter_en);
endmodule : sts_supervisor_checker

bind sts_supervisor sts_supervisor_checker u_chk (.clk, .rst, .temp_warn_cmp, .temp_shutdown_cmp,
    .filt_below_low_cmp, .save_warning_n_oe, .host_reset_request_n_oe, .fixed_converter_en,
    .adjustable_converter_en, .twenty_volt_en, .osc_en, .host_clock_out_sel);

// ### testbench/sts_host_model.sv
`timescale 1ns/1ps
// Host side of the open-drain pins; pull-ups lift a released pin.
module sts_host_model
(
    // Device drive.
    input wire logic sw_o,
    input wire logic sw_oe,
    input wire logic hr_o,
    input wire logic hr_oe,
    // Pin levels.
    output logic sw_i,
    output logic hr_i
);
    assign sw_i = sw_oe ? sw_o : 1'b1;
    assign hr_i = hr_oe ? hr_o : 1'b1;
endmodule : sts_host_model

// ### testbench/supply_thermal_watchdog_supervisor_tb.sv
`timescale 1ns/1ps
module supply_thermal_watchdog_supervisor_tb
    import sts_pkg::*;
;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [3:0] adr = 4'h0;
    logic [31:0] wdat = 32'h0;
    logic [N_IN-1:0] cmp = 14'h2000;
    logic [31:0] rdat, rv, seed = 32'd49853;
    logic wt, swo, swe, swi, hro, hre, hri, fce, ace, tve, ose;
    logic [1:0] csel;
    logic [3:0] c;
    int error_cnt = 0, n_checks = 0, n;
    always #5 clk = ~clk;
    sts_supervisor #(.OSC_DELAY_CYCLES(20), .BUS_FILTER_CYCLES(20), .CYCLES_PER_MS_P(10)) dut (
        .clk(clk), .rst(rst), .avs_address(adr), .avs_read(rd), .avs_write(wr),
        .avs_writedata(wdat), .avs_byteenable(4'hf), .avs_readdata(rdat), .avs_waitrequest(wt),
        .temp_warn_cmp(cmp[IN_TW]), .temp_shutdown_cmp(cmp[IN_TSD]),
        .filt_start_cmp(cmp[IN_FILT_START]), .filt_above_high_cmp(cmp[IN_FILT_HIGH]),
        .filt_below_low_cmp(cmp[IN_FILT_LOW]), .filt_above_off_cmp(cmp[IN_FILT_OFF]),
        .core_supply_ok_cmp(cmp[IN_CORE_OK]), .bus_above_high_cmp(cmp[IN_BUS_HIGH]),
        .bus_below_low_cmp(cmp[IN_BUS_LOW]), .adjustable_supply_ok(cmp[IN_ADJUSTABLE_SUPPLY_GOOD_OK]),
        .twenty_volt_ok(cmp[IN_V20_OK]), .osc_running(cmp[IN_OSC_RUN] && ose),
        .trim_read_done(cmp[IN_TRIM_DONE]), .fan_in_wake_pin(cmp[IN_WAKE]),
        .save_warning_n_i(swi), .save_warning_n_o(swo), .save_warning_n_oe(swe),
        .host_reset_request_n_i(hri), .host_reset_request_n_o(hro),
        .host_reset_request_n_oe(hre), .fixed_converter_en(fce), .adjustable_converter_en(ace),
        .twenty_volt_en(tve), .osc_en(ose), .host_clock_out_sel(csel));
    sts_host_model host (.sw_o(swo), .sw_oe(swe), .hr_o(hro), .hr_oe(hre), .sw_i(swi), .hr_i(hri));
    task automatic results();
        if (error_cnt == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : results
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // Bus request is held until waitrequest is seen low at a rising edge.
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        adr <= a;
        wdat <= d;
        wr <= w;
        rd <= !w;
        wfor(wt, 1'b0, 50, n);
        rv = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask : bus
    task automatic wfor(ref logic s, input logic v, input int lim, output int k);
        k = 0;
        while (s !== v && k < lim)
        begin
            @(posedge clk);
            k++;
        end
        if (s !== v)
        begin
            error_cnt++;
            results();
        end
    endtask : wfor
    task automatic st(input logic [31:0] m, input logic [31:0] e);
        bus(1'b0, ADDR_STATUS, 32'h0);
        chk(rv & m, e);
    endtask : st
    task automatic setc(input int i, input logic v);
        @(posedge clk);
        cmp[i] <= v;
    endtask : setc
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    initial
    begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk({wt, hre, swe, fce, csel}, {4'he, CLKSEL_OFF});
        cmp <= 14'h2024;
        repeat (6) @(posedge clk);
        chk({fce, hre}, 2'b11);
        cmp <= 14'h3eec;
        wfor(swe, 1'b0, 500, n);
        st(32'h3708, 32'h3308);
        chk({ose, ace, tve, csel}, {3'h7, CLKSEL_8M});
        bus(1'b0, 4'hc, 32'h0);
        chk(rv, 32'h0);
        setc(IN_TW, 1'b1);
        wfor(swe, 1'b1, 20, n);
        st(32'h1, 32'h1);
        setc(IN_TW, 1'b0);
        wfor(swe, 1'b0, 40, n);
        st(32'h1, 32'h0);
        setc(IN_TSD, 1'b1);
        wfor(hre, 1'b1, 20, n);
        repeat (4) @(posedge clk);
        chk({fce, ace, tve, ose}, 4'h0);
        st(32'h3702, 32'h2);
        st(32'h2, 32'h2);
        setc(IN_TSD, 1'b0);
        wfor(swe, 1'b0, 500, n);
        st(32'h2, 32'h2);
        st(32'h2, 32'h0);
        chk(hre, 1'b0);
        for (int i = 0; i < 3; i++)
        begin
            c = (i == 0) ? 4'h0 : 4'(rnd());
            bus(1'b1, ADDR_WDOG, {24'h0, c, 4'h1});
            repeat ((WD_EARLY_MS[c] + 1) * 10) @(posedge clk);
            bus(1'b1, ADDR_WDOG, {24'h0, c, 4'h1});
            wfor(hre, 1'b1, 6000, n);
            chk(n + 2 >= WD_TIMEOUT_MS[c] * 10 && n <= WD_TIMEOUT_MS[c] * 10 + 4, 1'b1);
            wfor(hre, 1'b0, 40, n);
            bus(1'b1, ADDR_WDOG, {24'h0, c, 4'h1});
            bus(1'b1, ADDR_WDOG, {24'h0, c, 4'h1});
            wfor(hre, 1'b1, 20, n);
            wfor(hre, 1'b0, 40, n);
        end
        setc(IN_WAKE, 1'b0);
        bus(1'b1, ADDR_CTRL, 32'h1);
        repeat (8) @(posedge clk);
        st(32'h700, 32'h300);
        setc(IN_WAKE, 1'b1);
        repeat (4) @(posedge clk);
        bus(1'b1, ADDR_CTRL, 32'h1);
        repeat (8) @(posedge clk);
        st(32'h700, 32'h400);
        setc(IN_WAKE, 1'b0);
        repeat (3) @(posedge clk);
        setc(IN_WAKE, 1'b1);
        repeat (10) @(posedge clk);
        wfor(swe, 1'b0, 500, n);
        st(32'h704, 32'h304);
        @(posedge clk);
        cmp[IN_BUS_HIGH] <= 1'b0;
        cmp[IN_BUS_LOW] <= 1'b1;
        wfor(swe, 1'b1, 60, n);
        chk(n >= 20 && n <= 26, 1'b1);
        st(32'h708, 32'h200);
        chk(csel, CLKSEL_8M);
        setc(IN_BUS_LOW, 1'b0);
        setc(IN_BUS_HIGH, 1'b1);
        wfor(swe, 1'b0, 60, n);
        setc(IN_OSC_RUN, 1'b0);
        wfor(swe, 1'b1, 20, n);
        st(32'h800, 32'h800);
        chk(csel, CLKSEL_4M);
        setc(IN_FILT_HIGH, 1'b0);
        setc(IN_FILT_LOW, 1'b1);
        repeat (6) @(posedge clk);
        chk({ace, tve}, 2'b00);
        results();
    end
endmodule : supply_thermal_watchdog_supervisor_tb
